// [hdl/ssc_pkg.sv]
// Constants, field layout and state encoding of the secure session control framer.
package ssc_pkg;

   // -------------------------------------------------------------------------
   // Frame layout
   // -------------------------------------------------------------------------
   localparam logic [7:0]  SSC_START_BYTE = 8'h7e;
   localparam logic [7:0]  SSC_TYPE_CTRL  = 8'h2e;
   localparam logic [7:0]  SSC_TYPE_RESP  = 8'hae;
   localparam logic [7:0]  SSC_CSUM_TOTAL = 8'hff;
   localparam logic [15:0] SSC_OFS_TYPE   = 16'h0003;
   localparam logic [15:0] SSC_OFS_DEST   = 16'h0004;
   localparam logic [15:0] SSC_OFS_OPT    = 16'h000c;
   localparam logic [15:0] SSC_OFS_TMO_HI = 16'h000d;
   localparam logic [15:0] SSC_OFS_TMO_LO = 16'h000e;
   localparam logic [15:0] SSC_MIN_LEN    = 16'h000c;
   localparam logic [15:0] SSC_LEN_TAIL   = 16'h0002;
   localparam logic [63:0] SSC_BCAST_ADDR = 64'h0000_0000_0000_ffff;

   // -------------------------------------------------------------------------
   // Option bits, timeout values and status codes
   // -------------------------------------------------------------------------
   localparam int          SSC_OPT_LOGOUT = 0;
   localparam int          SSC_OPT_TERM   = 1;
   localparam int          SSC_OPT_IPKT   = 2;
   localparam logic [15:0] SSC_TMO_YIELD  = 16'h0000;
   localparam logic [15:0] SSC_TMO_MAX    = 16'h4650;
   localparam logic [7:0]  SSC_STAT_OK    = 8'h00;
   localparam logic [7:0]  SSC_STAT_INVAL = 8'h0a;

   // -------------------------------------------------------------------------
   // Response frame and timing
   // -------------------------------------------------------------------------
   localparam logic [15:0] SSC_RSP_LEN    = 16'h0002;
   localparam logic [2:0]  SSC_RSP_LAST   = 3'h5;
   localparam int          SSC_TENTH_NS   = 100000000;
   localparam int          SSC_CLK_NS     = 8;
   localparam int          SSC_TICK_CYC   = SSC_TENTH_NS / SSC_CLK_NS;

   typedef enum logic [2:0] {
      SSC_IDLE = 3'b000,
      SSC_LENH = 3'b001,
      SSC_LENL = 3'b010,
      SSC_BODY = 3'b011,
      SSC_CSUM = 3'b100,
      SSC_RESP = 3'b101
   } ssc_state_t;

endpackage

// [hdl/ssc_buf2.sv]
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/100ps
module ssc_buf2 import ssc_pkg::*; #(
   parameter int W = 8
) (
   input  wire logic         sys_clk,
   input  wire logic         rst,
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);

   typedef struct packed {
      logic         hv;
      logic [W-1:0] hd;
      logic         tv;
      logic [W-1:0] td;
      logic         rdy;
   } ssc_buf_t;

   ssc_buf_t s_ff;
   ssc_buf_t nxt_s;

   // Head register feeds the output; the tail catches a word while the head stalls.
   always_comb begin
      nxt_s = s_ff;
      if (s_ff.hv && out_ready) begin
         nxt_s.hv = s_ff.tv;
         nxt_s.hd = s_ff.td;
         nxt_s.tv = 1'b0;
      end
      if (in_valid && s_ff.rdy) begin
         if (!nxt_s.hv) begin
            nxt_s.hv = 1'b1;
            nxt_s.hd = in_data;
         end else begin
            nxt_s.tv = 1'b1;
            nxt_s.td = in_data;
         end
      end
      nxt_s.rdy = !nxt_s.tv;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_ff <= '{hv: 1'b0, hd: '0, tv: 1'b0, td: '0, rdy: 1'b1};
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign in_ready  = s_ff.rdy;
   assign out_valid = s_ff.hv;
   assign out_data  = s_ff.hd;

   a_buf_hold_word: assert property (@(posedge sys_clk) disable iff (rst)
      out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("buffered word changed while stalled");

endmodule

// [hdl/ssc_framer.sv]
// Secure session control frame checker, session table and response framer.
`timescale 1ns/100ps
// Behaviour
// R1: Checksum is 0xff minus low byte of sum from frame type to last payload.
// R2: Sender puts 16-bit timeout in tenths of a second at offset 13, max 0x4650.
// R3: A zero timeout session is yielding and never expires by time.
// R4: With the table full, a new incoming request evicts the oldest yielding session.
// R5: Sessions with nonzero timeout are never evicted for a new request.
// R6: Option bit 2 clear: session ends once timeout elapses since start.
// R7: Option bit 2 set: timer restarts on each secure transmission with the peer.
// R8: Sender may combine option bits and clears all unused ones.
// R9: Password starts at offset 15, at most 64 ASCII characters.
// R10: Logout and termination requests ignore the password.
// R11: Termination ends the addressed node's session, or all on broadcast.
// R12: Host tracks multiple incoming sessions through extended status frames; this block sends none and reports sessions on sess_active and sess_ended.
// R13: A login request is answered with a 0xae response frame.
// R14: Control frame is type 0x2e at offset 3 after a start delimiter.
// R15: Length field counts bytes between length field and checksum.
// R16: Option bit 0 set means logout, ignoring other options and timeout.
// R17: Login to broadcast destination fails with status 0x0a.
// R18: A frame with bad checksum is dropped without session changes.
module ssc_framer import ssc_pkg::*; #(
   parameter int NSESS       = 4,
   parameter int TICK_CYCLES = SSC_TICK_CYC
) (
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire logic              in_valid,
   input  wire logic [7:0]        in_data,
   output logic                   in_ready,
   output logic                   out_valid,
   output logic [7:0]             out_data,
   input  wire logic              out_ready,
   input  wire logic              inc_req,
   input  wire logic [63:0]       inc_addr,
   input  wire logic [15:0]       inc_tmo,
   input  wire logic              inc_ipkt,
   input  wire logic              sec_traffic,
   input  wire logic [63:0]       sec_addr,
   output logic                   login_go,
   output logic [63:0]            login_dest,
   output logic [15:0]            login_tmo,
   output logic                   login_ipkt,
   output logic                   logout_go,
   output logic                   inc_admitted,
   output logic                   inc_refused,
   output logic [NSESS-1:0]       sess_active,
   output logic [NSESS-1:0]       sess_ended
);

   localparam int IW = (NSESS > 1) ? $clog2(NSESS) : 1;

   typedef struct packed {
      ssc_state_t              st;
      logic [15:0]             idx;
      logic [15:0]             len;
      logic [7:0]              sum;
      logic [7:0]              ftype;
      logic [63:0]             dest;
      logic [7:0]              opts;
      logic [15:0]             tmo;
      logic [2:0]              rsp_cnt;
      logic [7:0]              rsp_st;
      logic                    rdy;
      logic [31:0]             tick_cnt;
      logic [NSESS-1:0]        sv;
      logic [NSESS-1:0][63:0]  saddr;
      logic [NSESS-1:0][15:0]  stmo;
      logic [NSESS-1:0][15:0]  srem;
      logic [NSESS-1:0]        sip;
      logic [NSESS-1:0][7:0]   sage;
      logic [NSESS-1:0]        ended;
      logic                    login_go;
      logic                    logout_go;
      logic                    admitted;
      logic                    refused;
   } ssc_state_s_t;

   ssc_state_s_t s_ff;
   ssc_state_s_t nxt_s;

   logic          take;
   logic          csum_ok;
   logic          fr_done;
   logic          act;
   logic          tick;
   logic          free_found;
   logic          yield_found;
   logic [IW-1:0] free_idx;
   logic [IW-1:0] old_idx;
   logic [IW-1:0] slot;
   logic [7:0]    rsp_byte;
   logic          buf_rdy;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   // -------------------------------------------------------------------------
   // Response byte sequence
   // -------------------------------------------------------------------------
   always_comb begin
      unique case (s_ff.rsp_cnt)
         3'h0:    rsp_byte = SSC_START_BYTE;
         3'h1:    rsp_byte = SSC_RSP_LEN[15:8];
         3'h2:    rsp_byte = SSC_RSP_LEN[7:0];
         3'h3:    rsp_byte = SSC_TYPE_RESP;
         3'h4:    rsp_byte = s_ff.rsp_st;
         default: rsp_byte = 8'(SSC_CSUM_TOTAL - SSC_TYPE_RESP - s_ff.rsp_st);
      endcase
   end

   // -------------------------------------------------------------------------
   // Frame parser, session table and timers
   // -------------------------------------------------------------------------
   always_comb begin
      nxt_s           = s_ff;
      nxt_s.ended     = '0;
      nxt_s.login_go  = 1'b0;
      nxt_s.logout_go = 1'b0;
      nxt_s.admitted  = 1'b0;
      nxt_s.refused   = 1'b0;
      take    = in_valid && s_ff.rdy;
      csum_ok = 8'(s_ff.sum + in_data) == SSC_CSUM_TOTAL; // R1
      fr_done = take && (s_ff.st == SSC_CSUM);
      act     = fr_done && csum_ok && (s_ff.ftype == SSC_TYPE_CTRL)
                && (s_ff.len >= SSC_MIN_LEN); // R14 R15 R18
      tick    = s_ff.tick_cnt == 32'(TICK_CYCLES - 1);
      nxt_s.tick_cnt = tick ? 32'h0 : s_ff.tick_cnt + 32'h1;

      for (int i = 0; i < NSESS; i++) begin
         if (s_ff.sv[i] && s_ff.stmo[i] != SSC_TMO_YIELD) begin // R3
            if (sec_traffic && s_ff.sip[i] && s_ff.saddr[i] == sec_addr) begin
               nxt_s.srem[i] = s_ff.stmo[i]; // R7
            end else if (tick) begin
               if (s_ff.srem[i] <= 16'h0001) begin
                  nxt_s.sv[i]    = 1'b0; // R6
                  nxt_s.ended[i] = 1'b1;
               end else begin
                  nxt_s.srem[i] = s_ff.srem[i] - 16'h0001;
               end
            end
         end
      end

      if (take) begin
         unique case (s_ff.st)
            SSC_IDLE: begin
               if (in_data == SSC_START_BYTE) begin
                  nxt_s.st = SSC_LENH;
               end
            end
            SSC_LENH: begin
               nxt_s.len[15:8] = in_data;
               nxt_s.st        = SSC_LENL;
            end
            SSC_LENL: begin
               nxt_s.len[7:0] = in_data; // R15
               nxt_s.idx      = SSC_OFS_TYPE;
               nxt_s.sum      = 8'h00;
               nxt_s.ftype    = 8'h00;
               nxt_s.st       = ({s_ff.len[15:8], in_data} == 16'h0000) ? SSC_CSUM : SSC_BODY;
            end
            SSC_BODY: begin
               nxt_s.sum = 8'(s_ff.sum + in_data);
               if (s_ff.idx == SSC_OFS_TYPE) begin
                  nxt_s.ftype = in_data;
               end
               if (s_ff.idx >= SSC_OFS_DEST && s_ff.idx < SSC_OFS_OPT) begin
                  nxt_s.dest = {s_ff.dest[55:0], in_data};
               end
               if (s_ff.idx == SSC_OFS_OPT) begin
                  nxt_s.opts = in_data;
               end
               if (s_ff.idx == SSC_OFS_TMO_HI) begin
                  nxt_s.tmo[15:8] = in_data;
               end
               if (s_ff.idx == SSC_OFS_TMO_LO) begin
                  nxt_s.tmo[7:0] = in_data;
               end
               // Password bytes are summed only; authentication lies outside this block.
               if (s_ff.idx == 16'(s_ff.len + SSC_LEN_TAIL)) begin // R15
                  nxt_s.st = SSC_CSUM;
               end
               nxt_s.idx = s_ff.idx + 16'h0001;
            end
            default: begin
               nxt_s.st = SSC_IDLE; // R18
            end
         endcase
      end

      if (act) begin
         if (s_ff.opts[SSC_OPT_LOGOUT]) begin
            nxt_s.logout_go = 1'b1; // R16 R10
         end else if (s_ff.opts[SSC_OPT_TERM]) begin
            for (int i = 0; i < NSESS; i++) begin
               if (nxt_s.sv[i]
                   && (s_ff.dest == SSC_BCAST_ADDR || s_ff.saddr[i] == s_ff.dest)) begin
                  nxt_s.sv[i]    = 1'b0; // R11 R10
                  nxt_s.ended[i] = 1'b1;
               end
            end
         end else begin
            nxt_s.st      = SSC_RESP; // R13
            nxt_s.rsp_cnt = 3'h0;
            if (s_ff.dest == SSC_BCAST_ADDR) begin
               nxt_s.rsp_st = SSC_STAT_INVAL; // R17
            end else begin
               nxt_s.rsp_st   = SSC_STAT_OK;
               nxt_s.login_go = 1'b1;
            end
         end
      end

      if (s_ff.st == SSC_RESP && buf_rdy) begin
         nxt_s.rsp_cnt = s_ff.rsp_cnt + 3'h1;
         if (s_ff.rsp_cnt == SSC_RSP_LAST) begin
            nxt_s.st      = SSC_IDLE;
            nxt_s.rsp_cnt = 3'h0;
         end
      end

      free_found  = 1'b0;
      yield_found = 1'b0;
      free_idx    = '0;
      old_idx     = '0;
      for (int i = 0; i < NSESS; i++) begin
         if (!nxt_s.sv[i] && !free_found) begin
            free_found = 1'b1;
            free_idx   = IW'(i);
         end
         if (nxt_s.sv[i] && s_ff.stmo[i] == SSC_TMO_YIELD
             && (!yield_found || s_ff.sage[i] > s_ff.sage[old_idx])) begin // R5
            yield_found = 1'b1;
            old_idx     = IW'(i);
         end
      end
      slot = free_found ? free_idx : old_idx;

      if (inc_req) begin
         if (free_found || yield_found) begin
            if (!free_found) begin
               nxt_s.ended[old_idx] = 1'b1; // R4
            end
            for (int i = 0; i < NSESS; i++) begin
               if (nxt_s.sv[i] && s_ff.sage[i] != 8'hff) begin
                  nxt_s.sage[i] = s_ff.sage[i] + 8'h01;
               end
            end
            nxt_s.sv[slot]    = 1'b1;
            nxt_s.saddr[slot] = inc_addr;
            nxt_s.stmo[slot]  = inc_tmo;
            nxt_s.srem[slot]  = inc_tmo;
            nxt_s.sip[slot]   = inc_ipkt;
            nxt_s.sage[slot]  = 8'h00;
            nxt_s.admitted    = 1'b1;
         end else begin
            nxt_s.refused = 1'b1; // R5
         end
      end

      nxt_s.rdy = nxt_s.st != SSC_RESP;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s_ff     <= '0;
         s_ff.st  <= SSC_IDLE;
         s_ff.rdy <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // -------------------------------------------------------------------------
   // Outgoing buffer and outputs
   // -------------------------------------------------------------------------
   ssc_buf2 #(.W(8)) u_out_buf (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .in_valid  (s_ff.st == SSC_RESP),
      .in_data   (rsp_byte),
      .in_ready  (buf_rdy),
      .out_valid (out_valid),
      .out_data  (out_data),
      .out_ready (out_ready)
   );

   assign in_ready     = s_ff.rdy;
   assign login_go     = s_ff.login_go;
   assign login_dest   = s_ff.dest;
   assign login_tmo    = s_ff.tmo;
   assign login_ipkt   = s_ff.opts[SSC_OPT_IPKT];
   assign logout_go    = s_ff.logout_go;
   assign inc_admitted = s_ff.admitted;
   assign inc_refused  = s_ff.refused;
   assign sess_active  = s_ff.sv;
   assign sess_ended   = s_ff.ended;

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   a_csum_bad_drop: assert property ( // R18
      fr_done && !csum_ok |=> !s_ff.login_go && !s_ff.logout_go && s_ff.st == SSC_IDLE)
      else $error("bad checksum frame acted upon");
   a_csum_good_act: assert property ( // R1
      fr_done && csum_ok && s_ff.ftype == SSC_TYPE_CTRL && s_ff.len >= SSC_MIN_LEN
      && s_ff.opts[SSC_OPT_LOGOUT] |=> s_ff.logout_go)
      else $error("good checksum logout not acted upon");
   a_type_gate: assert property ( // R14
      fr_done && s_ff.ftype != SSC_TYPE_CTRL |=> !s_ff.login_go && !s_ff.logout_go)
      else $error("foreign frame type acted upon");
   a_login_resp: assert property ( // R13
      act && s_ff.opts[1:0] == 2'b00 |=> s_ff.st == SSC_RESP && !in_ready)
      else $error("login gave no response");
   a_bcast_login: assert property ( // R17
      act && s_ff.opts[1:0] == 2'b00 && s_ff.dest == SSC_BCAST_ADDR
      |=> s_ff.rsp_st == SSC_STAT_INVAL && !s_ff.login_go)
      else $error("broadcast login not refused");
   a_logout_quiet: assert property ( // R16
      act && s_ff.opts[SSC_OPT_LOGOUT] |=> s_ff.logout_go && s_ff.st == SSC_IDLE)
      else $error("logout mishandled");
   a_term_all: assert property ( // R11
      act && s_ff.opts[1:0] == 2'b10 && s_ff.dest == SSC_BCAST_ADDR && !inc_req
      |=> s_ff.sv == '0)
      else $error("broadcast termination left sessions");
   a_yield_keep: assert property ( // R3
      s_ff.sv[0] && s_ff.stmo[0] == SSC_TMO_YIELD && !inc_req && !fr_done |=> s_ff.sv[0])
      else $error("yielding session ended by time");
   a_evict_oldest: assert property ( // R4
      inc_req && !free_found && yield_found |=> s_ff.ended[$past(old_idx)] && s_ff.admitted)
      else $error("oldest yielding session not evicted");
   a_timed_refuse: assert property ( // R5
      inc_req && !free_found && !yield_found |=> s_ff.refused && !s_ff.admitted)
      else $error("timed session evicted or request admitted");
   a_fixed_expire: assert property ( // R6
      tick && s_ff.sv[0] && !s_ff.sip[0] && s_ff.stmo[0] != SSC_TMO_YIELD
      && s_ff.srem[0] == 16'h0001 |=> s_ff.ended[0])
      else $error("fixed session did not expire");
   a_ipkt_refresh: assert property ( // R7
      sec_traffic && s_ff.sv[0] && s_ff.sip[0] && s_ff.stmo[0] != SSC_TMO_YIELD
      && s_ff.saddr[0] == sec_addr && !fr_done && !inc_req
      |=> s_ff.sv[0] && s_ff.srem[0] == $past(s_ff.stmo[0]))
      else $error("inter-packet timer not restarted");

endmodule

// [sim/ssc_host_model.sv]
// Host controller model that sends framed requests and collects response bytes.
`timescale 1ns/100ps
module ssc_host_model import ssc_pkg::*; (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       in_ready,
   output logic            in_valid,
   output logic [7:0]      in_data,
   input  wire logic       out_valid,
   input  wire logic [7:0] out_data,
   output logic            out_ready
);
   logic [7:0] rx_q[$];
   logic       slow = 1'h0;
   logic [1:0] ph   = 2'h0;

   initial begin
      in_valid  = 1'h0;
      in_data   = 8'h00;
      out_ready = 1'h0;
   end

   // A slow receiver accepts only one cycle in four.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         out_ready <= 1'h0;
         ph        <= 2'h0;
      end else begin
         if (out_valid && out_ready)
            rx_q.push_back(out_data);
         ph        <= ph + 2'h1;
         out_ready <= !slow || (ph == 2'h3);
      end
   end

   // Entered just after a rising edge; each byte is held until in_ready is seen.
   task automatic send(input logic [7:0] typ, input logic [63:0] dest, input logic [7:0] opt,
                       input logic [15:0] tmo, input int npw, input logic bad);
      logic [7:0] f[$];
      logic [7:0] sum;
      f = {typ};
      for (int i = 7; i >= 0; i--)
         f.push_back(dest[i*8 +: 8]);
      f.push_back(opt);
      f.push_back(tmo[15:8]);
      f.push_back(tmo[7:0]);
      for (int i = 0; i < npw; i++)
         f.push_back(8'h41 + 8'(i));
      sum = 8'h00;
      foreach (f[i])
         sum += f[i];
      f.push_front(8'(f.size()));
      f.push_front(8'((f.size() - 1) >> 8));
      f.push_front(SSC_START_BYTE);
      f.push_back((SSC_CSUM_TOTAL - sum) ^ {7'h00, bad});
      foreach (f[i]) begin
         in_valid <= 1'h1;
         in_data  <= f[i];
         do @(posedge sys_clk); while (in_ready !== 1'h1);
      end
      in_valid <= 1'h0;
      in_data  <= ~in_data;
      @(posedge sys_clk);
   endtask
endmodule

// [sim/ssc_framer_test.sv]
// Self-checking testbench of the secure session control framer.
`timescale 1ns/100ps
module ssc_framer_test import ssc_pkg::*;;
   localparam int     TICK = 4;
   localparam logic [63:0] DST = 64'h0013_a200_1234_5678;
   logic        sys_clk = 1'h0;
   logic        rst = 1'h1;
   logic        in_valid, in_ready, out_valid, out_ready;
   logic [7:0]  in_data, out_data;
   logic        inc_req = 1'h0, inc_ipkt = 1'h0, sec_traffic = 1'h0;
   logic [63:0] inc_addr = 64'h0, sec_addr = 64'h0, login_dest;
   logic [15:0] inc_tmo = 16'h0, login_tmo;
   logic        login_go, login_ipkt, logout_go, inc_admitted, inc_refused;
   logic [3:0]  sess_active, sess_ended;
   int          fails = 0, checked = 0, n = 0, b = 0;
   int          n_login = 0, n_logout = 0, n_adm = 0, n_ref = 0;
   int          n_end[4] = '{default: 0};

   ssc_framer #(.NSESS(4), .TICK_CYCLES(TICK)) u_ssc_framer (.sys_clk(sys_clk), .rst(rst),
      .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready), .out_valid(out_valid),
      .out_data(out_data), .out_ready(out_ready), .inc_req(inc_req), .inc_addr(inc_addr),
      .inc_tmo(inc_tmo), .inc_ipkt(inc_ipkt), .sec_traffic(sec_traffic),
      .sec_addr(sec_addr), .login_go(login_go), .login_dest(login_dest),
      .login_tmo(login_tmo), .login_ipkt(login_ipkt), .logout_go(logout_go),
      .inc_admitted(inc_admitted), .inc_refused(inc_refused),
      .sess_active(sess_active), .sess_ended(sess_ended));

   ssc_host_model u_ssc_host_model (.sys_clk(sys_clk), .rst(rst), .in_ready(in_ready),
      .in_valid(in_valid), .in_data(in_data), .out_valid(out_valid),
      .out_data(out_data), .out_ready(out_ready));

   always #4 sys_clk = ~sys_clk;

   // One-cycle pulses are turned into running counts for the tests.
   always @(posedge sys_clk) begin
      n_login  <= n_login + int'(login_go === 1'h1);
      n_logout <= n_logout + int'(logout_go === 1'h1);
      n_adm    <= n_adm + int'(inc_admitted === 1'h1);
      n_ref    <= n_ref + int'(inc_refused === 1'h1);
      for (int i = 0; i < 4; i++)
         n_end[i] <= n_end[i] + int'(sess_ended[i] === 1'h1);
   end

   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk);
   endtask

   task automatic chk_val(input string what, input logic [63:0] exp, input logic [63:0] got);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_cnt(input string what, input int exp, input int got);
      checked++;
      if (got != exp) begin
         fails++;
         $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic expect_resp(input logic [7:0] st);
      logic [7:0] e[6];
      e = '{SSC_START_BYTE, SSC_RSP_LEN[15:8], SSC_RSP_LEN[7:0], SSC_TYPE_RESP, st,
            SSC_CSUM_TOTAL - SSC_TYPE_RESP - st};
      n = 0;
      while (u_ssc_host_model.rx_q.size() < 6 && n < 300) begin
         cyc(1);
         n++;
      end
      chk_cnt("response length", 6, u_ssc_host_model.rx_q.size());
      foreach (e[i])
         chk_val("response byte", e[i], u_ssc_host_model.rx_q[i]);
      u_ssc_host_model.rx_q.delete();
   endtask

   task automatic inc(input logic [63:0] a, input logic [15:0] t, input logic p);
      inc_req  <= 1'h1;
      inc_addr <= a;
      inc_tmo  <= t;
      inc_ipkt <= p;
      cyc(1);
      inc_req  <= 1'h0;
      cyc(2);
   endtask

   // Counts cycles until slot 0 ends, pulsing traffic to its peer every fourth cycle.
   task automatic run(input logic traf, input int lim, output int k);
      k = 0;
      while (sess_active[0] === 1'h1 && k < lim) begin
         sec_traffic <= traf && (k % 4 == 0);
         sec_addr    <= 64'hb0;
         cyc(1);
         k++;
      end
      sec_traffic <= 1'h0;
      cyc(1);
   endtask

   task automatic summarize();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      cyc(20000);
      fails++;
      summarize();
   end

   initial begin
      cyc(6);
      rst <= 1'h0;
      cyc(1);
      u_ssc_host_model.slow <= 1'h1;
      u_ssc_host_model.send(SSC_TYPE_CTRL, DST, 8'h00, 16'h0bb8, 8, 1'h0);
      cyc(2);
      chk_cnt("login pulse", 1, n_login);
      chk_val("login dest", DST, login_dest);
      chk_val("login timeout", 64'h0bb8, login_tmo);
      chk_val("login ipkt", 64'h0, login_ipkt);
      expect_resp(SSC_STAT_OK);
      u_ssc_host_model.send(SSC_TYPE_CTRL, DST, 8'h04, 16'h0258, 7, 1'h0);
      cyc(2);
      chk_val("login ipkt", 64'h1, login_ipkt);
      u_ssc_host_model.send(SSC_TYPE_CTRL, DST, 8'h07, 16'hffff, 5, 1'h0);
      cyc(2);
      chk_cnt("logout pulse", 1, n_logout);
      chk_cnt("login pulses", 2, n_login);
      expect_resp(SSC_STAT_OK);
      cyc(20);
      chk_cnt("logout response", 0, u_ssc_host_model.rx_q.size());
      $display("test login and logout done");
      u_ssc_host_model.send(SSC_TYPE_CTRL, SSC_BCAST_ADDR, 8'h00, 16'h0010, 3, 1'h0);
      expect_resp(SSC_STAT_INVAL);
      b = n_login;
      u_ssc_host_model.send(SSC_TYPE_CTRL, DST, 8'h00, 16'h0010, 3, 1'h1);
      u_ssc_host_model.send(8'h2f, DST, 8'h00, 16'h0010, 3, 1'h0);
      cyc(20);
      chk_cnt("dropped login", b, n_login);
      chk_cnt("dropped response", 0, u_ssc_host_model.rx_q.size());
      $display("test refused frames done");
      u_ssc_host_model.slow <= 1'h0;
      inc(64'ha0, 16'h0000, 1'h0);
      for (int i = 1; i < 4; i++)
         inc(64'ha0 + 64'(i), 16'h0100, 1'h0);
      cyc(100);
      chk_val("table full", 64'hf, sess_active);
      inc(64'ha4, 16'h0100, 1'h0);
      chk_cnt("eviction", 1, n_end[0]);
      chk_cnt("admissions", 5, n_adm);
      inc(64'ha5, 16'h0005, 1'h0);
      chk_cnt("refusal", 1, n_ref);
      chk_cnt("timed ends", 0, n_end[1] + n_end[2] + n_end[3]);
      u_ssc_host_model.send(SSC_TYPE_CTRL, 64'ha2, 8'h02, 16'h0000, 4, 1'h0);
      cyc(2);
      chk_val("one terminated", 64'hb, sess_active);
      u_ssc_host_model.send(SSC_TYPE_CTRL, SSC_BCAST_ADDR, 8'h02, 16'h0000, 0, 1'h0);
      cyc(2);
      chk_val("all terminated", 64'h0, sess_active);
      $display("test session table done");
      inc(64'hb0, 16'h0003, 1'h0);
      run(1'h1, 100, n);
      chk_cnt("fixed expiry", 1, int'(n >= 4 && n <= 3 * TICK + 2));
      inc(64'hb0, 16'h0003, 1'h1);
      run(1'h1, 60, n);
      chk_val("refreshed", 64'h1, sess_active[0]);
      run(1'h0, 100, n);
      chk_cnt("idle expiry", 1, int'(n >= 1 && n <= 3 * TICK + 2));
      $display("test timers done");
      summarize();
   end
endmodule
